// ### spi_err_pkg.sv
package spi_err_pkg;
  // register bus geometry and addresses
  localparam int           ADDR_W    = 16;
  localparam int           DATA_W    = 8;
  localparam logic [15:0]  CTRL_ADDR = 16'h0010;
  localparam logic [15:0]  STAT_ADDR = 16'h0011;
  localparam logic [15:0]  DATA_ADDR = 16'h0012;

  // control_reg field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CLOCK_PHASE_BIT = 1;
  localparam int CTRL_CPOL_BIT = 2;
  localparam int CTRL_MSTR_BIT = 3;
  localparam int CTRL_RXIE_BIT = 7;

  // status_control_reg field positions
  localparam int STAT_RATE_LSB  = 0;
  localparam int STAT_FDE_BIT   = 2;
  localparam int STAT_TXE_BIT   = 3;
  localparam int STAT_FLT_BIT   = 4;
  localparam int STAT_OVR_BIT   = 5;
  localparam int STAT_ERROR_IRQ_ENABLE_BIT = 6;
  localparam int STAT_RXF_BIT   = 7;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h08;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // master clock half periods in bus cycles, per rate_select code
  localparam int          HALF_W      = 7;
  localparam logic [6:0]  HALF_DIV2   = 7'h01;
  localparam logic [6:0]  HALF_DIV8   = 7'h04;
  localparam logic [6:0]  HALF_DIV32  = 7'h10;
  localparam logic [6:0]  HALF_DIV128 = 7'h40;

  // transfer framing
  localparam logic [3:0]  LAST_HALF = 4'hf;
  localparam logic [2:0]  LAST_BIT  = 3'h7;

  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } mstate_type;
endpackage

// ### spi_err_core.sv
// Function
// - master transfer starts only on data write
// - phase clear: clock idle for first half-bit
// - phase set: first bit opens with edge
// - master clock free-running, only enabled master
// - clock edges on rising edge of bus clock
// - start delay at most one bit time
// - overrun at first capture, keep old byte
// - overrun and fault share error interrupt enable
// - no rx full while overrun stands
// - status read then data read clears overrun
// - fault set only while detect enabled
// - master: select low sets fault
// - master fault: disable, tx empty, reset counter
// - fault leaves master_select untouched
// - slave: select rising mid-transfer sets fault
// - slave phase clear: frame from select fall
// - slave phase set: frame from clock edge
// - phase clear select pulse alone faults
// - slave fault keeps enable; toggle aborts
// - deselected slave tristates output, ignores clock
// - status read then control write clears fault
// - rx full set on every byte moved without overrun
module spi_err_core (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  // register port
  input  wire logic [spi_err_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [spi_err_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [spi_err_pkg::DATA_W-1:0] rdata_o,
  // serial link
  input  wire logic                          sck_i,
  output logic                               sck_o,
  output logic                               sck_oe_o,
  input  wire logic                          mosi_i,
  output logic                               mosi_o,
  output logic                               mosi_oe_o,
  input  wire logic                          miso_i,
  output logic                               miso_o,
  output logic                               miso_oe_o,
  input  wire logic                          ss_n_i,
  // system side
  output logic                               pins_owned_o,
  output logic                               rx_err_irq_o
);
  import spi_err_pkg::*;

  // rate_select to half bit period
  function automatic logic [HALF_W-1:0] half_len_f(input logic [1:0] code);
    case (code)
      2'h0:    half_len_f = HALF_DIV2;
      2'h1:    half_len_f = HALF_DIV8;
      2'h2:    half_len_f = HALF_DIV32;
      default: half_len_f = HALF_DIV128;
    endcase
  endfunction

  // configuration
  logic             en_r, en_nxt;
  logic             clock_phase_r, clock_phase_nxt;
  logic             cpol_r, cpol_nxt;
  logic             mstr_r, mstr_nxt;
  logic             rxie_r, rxie_nxt;
  logic [1:0]       rate_r, rate_nxt;
  logic             fde_r, fde_nxt;
  logic             error_irq_enable_r, error_irq_enable_nxt;
  // data and flags
  logic [7:0]       tx_buf_r, tx_buf_nxt;
  logic             txe_r, txe_nxt;
  logic [7:0]       rx_buf_r, rx_buf_nxt;
  logic             rxf_r, rxf_nxt;
  logic             ovr_r, ovr_nxt;
  logic             flt_r, flt_nxt;
  logic             arm_rxf_r, arm_rxf_nxt;
  logic             arm_ovr_r, arm_ovr_nxt;
  logic             arm_flt_r, arm_flt_nxt;
  logic [7:0]       rdata_r, rdata_nxt;
  // shift engine
  logic [HALF_W-1:0] div_r, div_nxt;
  logic             ph_r, ph_nxt;
  mstate_type       mst_r, mst_nxt;
  logic [3:0]       hcnt_r, hcnt_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic             smp_r, smp_nxt;
  logic             sck_r, sck_nxt;
  logic             sck_q_r, sck_q_nxt;
  logic             ss_q_r, ss_q_nxt;
  logic             sact_r, sact_nxt;
  logic [2:0]       bcnt_r, bcnt_nxt;

  // decode and event terms
  logic             run_clk, half_tick, bit_edge, mflt_cond, sflt_cond;
  logic             slv, lead, trail, ss_fall, ss_rise;
  logic             first_cap, done;
  logic [7:0]       rx_byte;
  logic [HALF_W-1:0] half_len;

  // next-state logic for registers, flags and both shift engines
  always_comb begin
    en_nxt      = en_r;
    clock_phase_nxt    = clock_phase_r;
    cpol_nxt    = cpol_r;
    mstr_nxt    = mstr_r;
    rxie_nxt    = rxie_r;
    rate_nxt    = rate_r;
    fde_nxt     = fde_r;
    error_irq_enable_nxt   = error_irq_enable_r;
    tx_buf_nxt  = tx_buf_r;
    txe_nxt     = txe_r;
    rx_buf_nxt  = rx_buf_r;
    rxf_nxt     = rxf_r;
    ovr_nxt     = ovr_r;
    flt_nxt     = flt_r;
    arm_rxf_nxt = arm_rxf_r;
    arm_ovr_nxt = arm_ovr_r;
    arm_flt_nxt = arm_flt_r;
    rdata_nxt   = rdata_r;
    div_nxt     = div_r;
    ph_nxt      = ph_r;
    mst_nxt     = mst_r;
    hcnt_nxt    = hcnt_r;
    sh_nxt      = sh_r;
    smp_nxt     = smp_r;
    sck_nxt     = sck_r;
    sck_q_nxt   = sck_i;
    ss_q_nxt    = ss_n_i;
    sact_nxt    = sact_r;
    bcnt_nxt    = bcnt_r;
    first_cap   = 1'b0;
    done        = 1'b0;
    rx_byte     = 8'h00;

    run_clk   = en_r & mstr_r;
    half_len  = half_len_f(rate_r);
    half_tick = run_clk & (div_r == half_len - 7'h01);
    bit_edge  = half_tick & ph_r;
    slv       = en_r & ~mstr_r;
    // a deselected slave sees no clock edges at all
    lead      = slv & ~ss_n_i & (sck_i != sck_q_r) & (sck_q_r == cpol_r);
    trail     = slv & ~ss_n_i & (sck_i != sck_q_r) & (sck_q_r != cpol_r);
    ss_fall   = slv & ss_q_r & ~ss_n_i;
    ss_rise   = slv & ~ss_q_r & ss_n_i;
    mflt_cond = run_clk & fde_r & ~ss_n_i;
    sflt_cond = ss_rise & sact_r & fde_r;

    // bus side: reads arm the two-step clears, writes store fields
    rdata_nxt = 8'h00;
    if (rd_i) begin
      case (addr_i)
        CTRL_ADDR: rdata_nxt = {rxie_r, 3'h0, mstr_r, cpol_r, clock_phase_r, en_r};
        STAT_ADDR: begin
          rdata_nxt   = {rxf_r, error_irq_enable_r, ovr_r, flt_r, txe_r, fde_r, rate_r};
          arm_rxf_nxt = rxf_r;
          arm_ovr_nxt = ovr_r;
          arm_flt_nxt = flt_r;
        end
        DATA_ADDR: begin
          rdata_nxt = rx_buf_r;
          if (arm_rxf_r) begin
            rxf_nxt = 1'b0;
          end
          if (arm_ovr_r) begin
            ovr_nxt = 1'b0;
          end
          arm_rxf_nxt = 1'b0;
          arm_ovr_nxt = 1'b0;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        CTRL_ADDR: begin
          en_nxt   = wdata_i[CTRL_EN_BIT];
          clock_phase_nxt = wdata_i[CTRL_CLOCK_PHASE_BIT];
          cpol_nxt = wdata_i[CTRL_CPOL_BIT];
          mstr_nxt = wdata_i[CTRL_MSTR_BIT];
          rxie_nxt = wdata_i[CTRL_RXIE_BIT];
          // clear only if no fault condition stands right now; a master that
          // disabled itself still sees select low as a standing fault
          if (arm_flt_r & ~(mstr_r & fde_r & ~ss_n_i) & ~sflt_cond) begin
            flt_nxt = 1'b0;
          end
          arm_flt_nxt = 1'b0;
        end
        STAT_ADDR: begin
          rate_nxt  = wdata_i[STAT_RATE_LSB +: 2];
          fde_nxt   = wdata_i[STAT_FDE_BIT];
          error_irq_enable_nxt = wdata_i[STAT_ERROR_IRQ_ENABLE_BIT];
        end
        DATA_ADDR: begin
          tx_buf_nxt = wdata_i;
          txe_nxt    = 1'b0;
        end
        default: ;
      endcase
    end

    // free-running divider, stopped unless enabled master
    if (run_clk) begin
      div_nxt = half_tick ? 7'h00 : div_r + 7'h01;
      if (half_tick) begin
        ph_nxt = ~ph_r;
      end
    end else begin
      div_nxt = 7'h00;
      ph_nxt  = 1'b0;
      sck_nxt = cpol_r;
    end

    // master engine: 16 half periods per byte
    case (mst_r)
      M_IDLE: begin
        // only a pending data write starts, at the next bit boundary
        if (bit_edge & ~txe_r & ~(wr_i & (addr_i == DATA_ADDR))) begin
          mst_nxt  = M_RUN;
          hcnt_nxt = 4'h0;
          sh_nxt   = tx_buf_r;
          txe_nxt  = 1'b1;
          sck_nxt  = cpol_r ^ clock_phase_r;
        end
      end
      M_RUN: begin
        if (half_tick) begin
          // capture at the end of even halves (phase 0) or odd (phase 1)
          if (hcnt_r[0] == clock_phase_r) begin
            smp_nxt   = miso_i;
            first_cap = (hcnt_r[3:1] == 3'h0);
          end
          if (hcnt_r[0]) begin
            sh_nxt = {sh_r[6:0], clock_phase_r ? miso_i : smp_r};
          end
          if (hcnt_r == LAST_HALF) begin
            done     = 1'b1;
            rx_byte  = {sh_r[6:0], clock_phase_r ? miso_i : smp_r};
            mst_nxt  = M_IDLE;
            sck_nxt  = cpol_r;
          end else begin
            hcnt_nxt = hcnt_r + 4'h1;
            // edges land on rising bus clock edges, the same edge the register port samples on
            sck_nxt  = cpol_r ^ ~(hcnt_r[0] ^ clock_phase_r);
          end
        end
      end
      default: mst_nxt = M_IDLE;
    endcase

    // slave engine
    if (~clock_phase_r & ss_fall) begin
      sact_nxt = 1'b1;
      bcnt_nxt = 3'h0;
      if (~txe_r) begin
        sh_nxt  = tx_buf_r;
        txe_nxt = 1'b1;
      end
    end
    if (lead) begin
      if (clock_phase_r) begin
        if (~sact_r) begin
          sact_nxt = 1'b1;
          bcnt_nxt = 3'h0;
          if (~txe_r) begin
            sh_nxt  = tx_buf_r;
            txe_nxt = 1'b1;
          end
        end else begin
          sh_nxt = {sh_r[6:0], smp_r};
        end
      end else if (sact_r) begin
        smp_nxt   = mosi_i;
        first_cap = (bcnt_r == 3'h0);
      end
    end
    if (trail & sact_r) begin
      if (clock_phase_r) begin
        first_cap = (bcnt_r == 3'h0);
      end
      sh_nxt   = {sh_r[6:0], clock_phase_r ? mosi_i : smp_r};
      bcnt_nxt = bcnt_r + 3'h1;
      if (bcnt_r == LAST_BIT) begin
        done     = 1'b1;
        rx_byte  = {sh_r[6:0], clock_phase_r ? mosi_i : smp_r};
        sact_nxt = 1'b0;
      end
    end
    if (ss_rise) begin
      sact_nxt = 1'b0;
    end

    // receive side: overrun wins over new data
    if (first_cap & rxf_r) begin
      ovr_nxt = 1'b1;
    end
    if (done & ~ovr_nxt) begin
      rx_buf_nxt = rx_byte;
      rxf_nxt    = 1'b1;
    end

    // fault handling; mstr is left alone so software can tell the mode
    if (sflt_cond) begin
      flt_nxt = 1'b1;
    end
    if (mflt_cond) begin
      flt_nxt = 1'b1;
      en_nxt  = 1'b0;
      txe_nxt = 1'b1;
      mst_nxt = M_IDLE;
      hcnt_nxt = 4'h0;
    end

    // partial reset while disabled: aborts any frame, master or slave
    if (~en_r) begin
      txe_nxt  = 1'b1;
      mst_nxt  = M_IDLE;
      hcnt_nxt = 4'h0;
      sh_nxt   = 8'h00;
      sact_nxt = 1'b0;
      bcnt_nxt = 3'h0;
    end
  end

  // state registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      en_r      <= CTRL_RESET[CTRL_EN_BIT];
      clock_phase_r    <= CTRL_RESET[CTRL_CLOCK_PHASE_BIT];
      cpol_r    <= CTRL_RESET[CTRL_CPOL_BIT];
      mstr_r    <= CTRL_RESET[CTRL_MSTR_BIT];
      rxie_r    <= CTRL_RESET[CTRL_RXIE_BIT];
      rate_r    <= STAT_RESET[STAT_RATE_LSB +: 2];
      fde_r     <= STAT_RESET[STAT_FDE_BIT];
      error_irq_enable_r   <= STAT_RESET[STAT_ERROR_IRQ_ENABLE_BIT];
      tx_buf_r  <= DATA_RESET;
      txe_r     <= STAT_RESET[STAT_TXE_BIT];
      rx_buf_r  <= DATA_RESET;
      rxf_r     <= STAT_RESET[STAT_RXF_BIT];
      ovr_r     <= STAT_RESET[STAT_OVR_BIT];
      flt_r     <= STAT_RESET[STAT_FLT_BIT];
      arm_rxf_r <= 1'b0;
      arm_ovr_r <= 1'b0;
      arm_flt_r <= 1'b0;
      rdata_r   <= 8'h00;
      div_r     <= 7'h00;
      ph_r      <= 1'b0;
      mst_r     <= M_IDLE;
      hcnt_r    <= 4'h0;
      sh_r      <= DATA_RESET;
      smp_r     <= 1'b0;
      sck_r     <= 1'b0;
      sck_q_r   <= 1'b0;
      ss_q_r    <= 1'b1;
      sact_r    <= 1'b0;
      bcnt_r    <= 3'h0;
    end else begin
      en_r      <= en_nxt;
      clock_phase_r    <= clock_phase_nxt;
      cpol_r    <= cpol_nxt;
      mstr_r    <= mstr_nxt;
      rxie_r    <= rxie_nxt;
      rate_r    <= rate_nxt;
      fde_r     <= fde_nxt;
      error_irq_enable_r   <= error_irq_enable_nxt;
      tx_buf_r  <= tx_buf_nxt;
      txe_r     <= txe_nxt;
      rx_buf_r  <= rx_buf_nxt;
      rxf_r     <= rxf_nxt;
      ovr_r     <= ovr_nxt;
      flt_r     <= flt_nxt;
      arm_rxf_r <= arm_rxf_nxt;
      arm_ovr_r <= arm_ovr_nxt;
      arm_flt_r <= arm_flt_nxt;
      rdata_r   <= rdata_nxt;
      div_r     <= div_nxt;
      ph_r      <= ph_nxt;
      mst_r     <= mst_nxt;
      hcnt_r    <= hcnt_nxt;
      sh_r      <= sh_nxt;
      smp_r     <= smp_nxt;
      sck_r     <= sck_nxt;
      sck_q_r   <= sck_q_nxt;
      ss_q_r    <= ss_q_nxt;
      sact_r    <= sact_nxt;
      bcnt_r    <= bcnt_nxt;
    end
  end

  // pins: enables follow mode, data from the shift register
  assign rdata_o      = rdata_r;
  assign sck_o        = sck_r;
  assign sck_oe_o     = en_r & mstr_r;
  assign mosi_o       = sh_r[7];
  assign mosi_oe_o    = en_r & mstr_r;
  assign miso_o       = sh_r[7];
  assign miso_oe_o    = en_r & ~mstr_r & ~ss_n_i;
  assign pins_owned_o = en_r;
  // one shared line: receive full plus the two errors behind one enable
  assign rx_err_irq_o = (rxie_r & en_r & rxf_r) | (error_irq_enable_r & (ovr_r | flt_r));
endmodule

// ### spi_err_core_asserts.sv
module spi_err_core_chk (
  // clock and reset
  input wire logic                           sys_clk_i,
  input wire logic                           rst_i,
  // register port
  input wire logic [spi_err_pkg::ADDR_W-1:0] addr_i,
  input wire logic [spi_err_pkg::DATA_W-1:0] wdata_i,
  input wire logic                           wr_i,
  // serial link and pin ownership
  input wire logic                           sck_o,
  input wire logic                           sck_oe_o,
  input wire logic                           mosi_oe_o,
  input wire logic                           miso_oe_o,
  input wire logic                           ss_n_i,
  input wire logic                           pins_owned_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import spi_err_pkg::*;

  logic        fde_r;
  logic        fde_nxt;
  logic [11:0] since_wr_r;
  logic [11:0] since_wr_nxt;
  logic        ctrl_wr;

  assign ctrl_wr = wr_i && (addr_i == CTRL_ADDR);

  // shadow of the fault-detect bit, and age of the last data write (saturates)
  always_comb begin
    fde_nxt = fde_r;
    since_wr_nxt = (since_wr_r == 12'hfff) ? since_wr_r : since_wr_r + 12'h001;
    if (wr_i && addr_i == STAT_ADDR) fde_nxt = wdata_i[STAT_FDE_BIT];
    if (wr_i && addr_i == DATA_ADDR) since_wr_nxt = 12'h000;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fde_r      <= 1'h0;
      since_wr_r <= 12'hfff;
    end else begin
      fde_r      <= fde_nxt;
      since_wr_r <= since_wr_nxt;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // the serial clock only moves while the divider is allowed to run, or when it parks at the polarity level
  a_sck_parked: assert property (!sck_oe_o && !$past(sck_oe_o) && !$past(sck_oe_o, 2) && !$past(wr_i)
    && !$past(wr_i, 2) |-> $stable(sck_o)) else $error("serial clock moved while parked");
  a_oe_pair: assert property (mosi_oe_o == sck_oe_o) else $error("data and clock drivers disagree");
  a_owned_oe: assert property (sck_oe_o || miso_oe_o |-> pins_owned_o)
    else $error("pin driven while port logic owns it");
  a_miso_hiz: assert property (ss_n_i |-> !miso_oe_o) else $error("slave output driven while deselected");
  a_slave_drive: assert property (!ss_n_i && pins_owned_o && !sck_oe_o |-> miso_oe_o)
    else $error("selected slave left its output off");
  // 2400 covers a queued byte behind a full slow transfer
  a_start_write: assert property (sck_oe_o && $past(sck_oe_o) && $changed(sck_o) |-> since_wr_r < 12'h960)
    else $error("serial clock ran with no data write behind it");
  a_master_fault: assert property (sck_oe_o && !ss_n_i && fde_r |-> ##[1:3] !sck_oe_o)
    else $error("master kept driving after select went low");
  a_slave_keeps: assert property (pins_owned_o && !sck_oe_o && !ctrl_wr |=> pins_owned_o)
    else $error("slave lost its enable without a control write");
  a_no_self_en: assert property (!pins_owned_o && !ctrl_wr |=> !pins_owned_o)
    else $error("module enabled itself");
endmodule

// ### spi_err_peer.sv
module spi_err_peer (
  // link side
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       clock_phase_i,
  output logic            miso_o,
  // bench side: preload and collected byte
  input  wire logic       load_i,
  input  wire logic [7:0] byte_i,
  output logic [7:0]      got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_r = 8'h00;
  logic       smp_r = 1'h0;
  logic       out_r = 1'h0;

  always @(posedge load_i) sh_r <= byte_i;
  // leading edge: phase 0 samples, phase 1 presents the next bit
  always @(posedge sck_i) begin
    if (!clock_phase_i) smp_r <= mosi_i;
    else out_r <= sh_r[7];
  end
  // trailing edge moves the received bit in, msb first
  always @(negedge sck_i) sh_r <= {sh_r[6:0], clock_phase_i ? mosi_i : smp_r};
  assign miso_o = clock_phase_i ? out_r : sh_r[7];
  assign got_o  = sh_r;
endmodule

// ### test_spi_start_latency_and_error_flags.sv
module test_spi_start_latency_and_error_flags;
  timeunit 1ns;
  timeprecision 1ns;
  import spi_err_pkg::*;
  logic        sys_clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'h0;
  logic        rd_s = 1'h0;
  logic        ss_n = 1'h1;
  logic        s_sck = 1'h0;
  logic        s_mosi = 1'h0;
  logic        pk_load = 1'h0;
  logic        pk_clock_phase = 1'h0;
  logic [7:0]  pk_byte = 8'h00;
  logic [7:0]  rdata, pk_got;
  logic        sck_o, mosi_o, pk_miso, owned, irq, miso_oe;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;

  spi_err_core uut (
    .sys_clk_i, .rst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .sck_i(s_sck), .sck_o, .sck_oe_o(), .mosi_i(s_mosi), .mosi_o, .mosi_oe_o(), .miso_i(pk_miso),
    .miso_o(), .miso_oe_o(miso_oe), .ss_n_i(ss_n), .pins_owned_o(owned), .rx_err_irq_o(irq));
  spi_err_peer peer (.sck_i(sck_o), .mosi_i(mosi_o), .clock_phase_i(pk_clock_phase), .miso_o(pk_miso),
    .load_i(pk_load), .byte_i(pk_byte), .got_o(pk_got));

  always #25 sys_clk_i = ~sys_clk_i;
  // a hang ends the run after far more cycles than the sequence needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // strobes drop one edge after rising, so back-to-back calls leave a gap cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge sys_clk_i);
    wr_s <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge sys_clk_i);
    rd_s <= 1'h0;
    #1 chk(nm, rdata, e);
  endtask
  // one master byte: preload peer, write data, time the first clock edge
  task automatic xfer(input logic [7:0] tx, input logic [7:0] pb, input int h, input int ph);
    int n;
    pk_clock_phase = ph[0];
    pk_byte = pb;
    pk_load = 1'h1;
    #1 pk_load = 1'h0;
    wr(DATA_ADDR, tx);
    n = 0;
    #1;
    while (sck_o === 1'h0 && n < 4 * h + 8) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("first_edge", {7'h0, sck_o}, 8'h01);
    chk("late_start", {7'h0, n <= 2 * h + 2 + (1 - ph) * h}, 8'h01);
    chk("early_edge", {7'h0, n >= h * (1 - ph)}, 8'h01);
    idle(16 * h + 4);
  endtask
  // one slave byte, phase 0: select, eight clocks of two-cycle halves, deselect
  task automatic sxfer(input logic [7:0] b);
    ss_n <= 1'h0;
    idle(2);
    for (int i = 7; i >= 0; i--) begin
      s_mosi <= b[i];
      idle(2);
      s_sck <= 1'h1;
      idle(2);
      s_sck <= 1'h0;
    end
    idle(3);
    ss_n <= 1'h1;
    idle(2);
  endtask

  initial begin
    logic [7:0] tx;
    int h;
    void'($urandom(99));
    idle(20);
    rst_i <= 1'h0;
    // reset values, then an unmapped place that must stay empty
    rchk("ctrl", CTRL_ADDR, CTRL_RESET);
    rchk("stat", STAT_ADDR, STAT_RESET);
    rchk("data", DATA_ADDR, DATA_RESET);
    wr(16'h0013, 8'hff);
    rchk("unmapped", 16'h0013, 8'h00);
    // every rate under both phases, random bytes both ways
    for (int ph = 0; ph < 2; ph++) begin
      for (int r = 0; r < 4; r++) begin
        h = 1 << (2 * r);
        tx = 8'($urandom);
        wr(CTRL_ADDR, 8'h00);
        wr(STAT_ADDR, 8'(r));
        wr(CTRL_ADDR, 8'h89 | 8'(ph << 1));
        xfer(tx, ~tx ^ 8'(r), h, ph);
        chk("irq", {7'h0, irq}, 8'h01);
        rchk("stat", STAT_ADDR, 8'h88 | 8'(r));
        rchk("rx", DATA_ADDR, ~tx ^ 8'(r));
        chk("peer", pk_got, tx);
      end
    end
    // overrun missed between status and data reads
    wr(CTRL_ADDR, 8'h00);
    wr(STAT_ADDR, 8'h40);
    wr(CTRL_ADDR, 8'h09);
    xfer(8'($urandom), 8'h5a, 1, 0);
    rchk("stat", STAT_ADDR, 8'hc8);
    xfer(8'h00, 8'ha5, 1, 0);
    chk("irq", {7'h0, irq}, 8'h01);
    rchk("kept", DATA_ADDR, 8'h5a);
    xfer(8'hff, 8'h3c, 1, 0);
    rchk("stat", STAT_ADDR, 8'h68);
    rchk("kept", DATA_ADDR, 8'h5a);
    rchk("stat", STAT_ADDR, 8'h48);
    chk("irq", {7'h0, irq}, 8'h00);
    // master fault while the written byte still waits for its first bit edge, clear refused while select is low
    wr(STAT_ADDR, 8'h47);
    wr(DATA_ADDR, 8'($urandom));
    idle(40);
    ss_n <= 1'h0;
    idle(4);
    chk("owned", {7'h0, owned}, 8'h00);
    chk("irq", {7'h0, irq}, 8'h01);
    rchk("ctrl", CTRL_ADDR, 8'h08);
    rchk("stat", STAT_ADDR, 8'h5f);
    wr(CTRL_ADDR, 8'h08);
    rchk("stat", STAT_ADDR, 8'h5f);
    wr(STAT_ADDR, 8'h43);
    rchk("stat", STAT_ADDR, 8'h5b);
    ss_n <= 1'h1;
    wr(CTRL_ADDR, 8'h08);
    rchk("stat", STAT_ADDR, 8'h4b);
    wr(CTRL_ADDR, 8'h09);
    ss_n <= 1'h0;
    idle(4);
    rchk("stat", STAT_ADDR, 8'h4b);
    chk("owned", {7'h0, owned}, 8'h01);
    ss_n <= 1'h1;
    // slave select pulse with no clocks, phase 0 then phase 1
    wr(CTRL_ADDR, 8'h00);
    wr(STAT_ADDR, 8'h44);
    wr(CTRL_ADDR, 8'h01);
    ss_n <= 1'h0;
    idle(4);
    chk("miso_oe", {7'h0, miso_oe}, 8'h01);
    ss_n <= 1'h1;
    idle(4);
    chk("owned", {7'h0, owned}, 8'h01);
    rchk("stat", STAT_ADDR, 8'h5c);
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h03);
    ss_n <= 1'h0;
    idle(4);
    ss_n <= 1'h1;
    idle(4);
    rchk("stat", STAT_ADDR, 8'h4c);
    // a full slave byte in phase 0, framed by select
    tx = 8'($urandom);
    wr(CTRL_ADDR, 8'h01);
    sxfer(tx);
    rchk("stat", STAT_ADDR, 8'hcc);
    rchk("slave_rx", DATA_ADDR, tx);
    tally_and_finish();
  end
endmodule

bind spi_err_core spi_err_core_chk chk_i (
  .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .sck_o, .sck_oe_o, .mosi_oe_o, .miso_oe_o, .ss_n_i, .pins_owned_o);
